//--- pcs_pkg.sv
package pcs_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RUN_CTRL = 8'h01;
  localparam logic [7:0] CMD_ON_SRC = 8'h02;
  localparam logic [7:0] CMD_STORE_DEF = 8'h11;
  localparam logic [7:0] CMD_RESTORE_DEF = 8'h12;
  localparam logic [7:0] CMD_STORE_USER = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
  localparam logic [7:0] CMD_VFMT = 8'h20;
  localparam logic [7:0] CMD_TARGET = 8'h21;
  localparam logic [7:0] CMD_TRIM = 8'h22;
  localparam logic [7:0] CMD_CAL = 8'h23;
  localparam logic [7:0] CMD_UPPER = 8'h24;
  localparam logic [7:0] CMD_MHIGH = 8'h25;
  localparam logic [7:0] CMD_MLOW = 8'h26;
  localparam logic [7:0] CMD_SLEW = 8'h27;
  localparam logic [7:0] CMD_LOADLINE = 8'h28;
  localparam logic [7:0] CMD_DUTY = 8'h32;
  localparam logic [7:0] CMD_FSW = 8'h33;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RUN_CTRL = 8'h00;
  localparam logic [7:0] RST_ON_SRC = 8'h16;
  localparam logic [7:0] RST_VFMT = 8'h13;
  localparam logic [15:0] RST_TRIM = 16'h0000;
  localparam logic [15:0] RST_CAL = 16'h0000;
  localparam logic [15:0] RST_SLEW = 16'hba00;
  localparam logic [15:0] RST_LOADLINE = 16'h0000;
  localparam logic [15:0] RST_DUTY = 16'head6;
  // ----------------------------------------------------------------
  // Setting slots and field positions
  // ----------------------------------------------------------------
  localparam int NSLOT = 12;
  localparam int SL_RUN = 0;
  localparam int SL_ONSRC = 1;
  localparam int SL_TARGET = 2;
  localparam int SL_TRIM = 3;
  localparam int SL_CAL = 4;
  localparam int SL_UPPER = 5;
  localparam int SL_MHIGH = 6;
  localparam int SL_MLOW = 7;
  localparam int SL_SLEW = 8;
  localparam int SL_LOADLINE = 9;
  localparam int SL_DUTY = 10;
  localparam int SL_FSW = 11;
  localparam int RUN_ON_BIT = 7;
  localparam int MARGIN_HI = 5;
  localparam int MARGIN_LO = 4;
  localparam int ONSRC_CMD_BIT = 3;
  localparam int ONSRC_PIN_BIT = 2;
  localparam logic [1:0] MG_HIGH = 2'h2;
  localparam logic [1:0] MG_LOW = 2'h1;
  // Wait cycles before each slot write into a store; one slot takes NV_WAIT + 1 cycles
  localparam logic [3:0] NV_WAIT = 4'h3;
  typedef enum logic [4:0] {
    ST_INIT = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_STORE = 5'b00100,
    ST_LOAD = 5'b01000,
    ST_WAIT = 5'b10000
  } pcs_state_t;
endpackage

//--- pcs_config_store.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - At initialisation, load working settings from the nonvolatile store; resetn clears both stores, so init loads reset and strap values.
// - Two stores exist: a default store and a user store.
// - Restore only from a store the user has been granted access to; user restore falls back to the default store without default_restore_ok.
// - Command 11h writes settings changed since last restore to default store.
// - Command 12h reloads working settings from the default store.
// - Command 15h writes settings changed since last restore to user store.
// - Command 16h reloads working settings from the user store.
// - Byte 02h chooses pin or command turn-on.
// - Byte 01h turns output on or off and picks margin mode.
// - Byte 20h reads linear format, exponent -13.
// - Word 21h holds nominal target, reset from pin strap.
// - Word 22h holds signed trim, reset 0000h.
// - Word 23h offset is added to the nominal target, reset 0000h.
// - Word 24h upper limit defaults to 1.1 times strapped voltage.
// - Words 25h and 26h hold margin targets used in margin modes.
// - Word 27h sets slew rate, reset BA00h.
// - Word 28h holds droop resistance, reset zero.
// - Word 32h limits duty cycle, reset EAD6h.
// - Word 33h sets switching frequency, reset from pin strap.
module pcs_config_store
  import pcs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic cmd_valid, // One-cycle command strobe
  input wire logic [7:0] cmd_code, // Command code
  input wire logic cmd_write, // High for write or send byte
  input wire logic [15:0] cmd_wdata, // Write data, bytes in low bits
  input wire logic [15:0] strap_vout, // Pin-strapped target voltage
  input wire logic [15:0] strap_fsw, // Pin-strapped switching frequency
  input wire logic user_restore_ok, // User store access granted
  input wire logic default_restore_ok, // Default store access granted
  input wire logic enable_pin, // Enable pin, asynchronous
  output logic [15:0] rsp_data, // Read answer data
  output logic rsp_valid, // Read answer strobe
  output logic cmd_busy, // Store or restore running
  output logic cmd_refused, // Pulse: command refused
  output logic output_on, // Output run state
  output logic [15:0] active_target, // Selected target plus offset
  output logic [15:0] slew_out, // Active slew rate word
  output logic [15:0] loadline_out, // Active droop word
  output logic [15:0] duty_limit_out, // Active duty ceiling
  output logic [15:0] fsw_out, // Active switching frequency
  output logic [15:0] upper_limit_out // Active upper voltage limit
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] work_reg [NSLOT];
  logic [15:0] def_mem [NSLOT];
  logic [15:0] user_mem [NSLOT];
  logic [NSLOT-1:0] dirty_reg;
  logic [NSLOT-1:0] def_valid_reg;
  logic [NSLOT-1:0] user_valid_reg;
  pcs_state_t state_reg;
  logic [3:0] slot_reg;
  logic [3:0] wait_reg;
  logic to_user_reg;
  logic en_s1_reg, en_s2_reg;
  logic [15:0] vout_s1_reg, vout_s2_reg;
  logic [15:0] fsw_s1_reg, fsw_s2_reg;
  logic [15:0] tgt_next;
  logic [4:0] wslot;
  logic hit;
  logic is_cmd;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    if (cmd_code == CMD_RUN_CTRL) wslot = 5'(SL_RUN);
    else if (cmd_code == CMD_ON_SRC) wslot = 5'(SL_ONSRC);
    else if (cmd_code == CMD_TARGET) wslot = 5'(SL_TARGET);
    else if (cmd_code == CMD_TRIM) wslot = 5'(SL_TRIM);
    else if (cmd_code == CMD_CAL) wslot = 5'(SL_CAL);
    else if (cmd_code == CMD_UPPER) wslot = 5'(SL_UPPER);
    else if (cmd_code == CMD_MHIGH) wslot = 5'(SL_MHIGH);
    else if (cmd_code == CMD_MLOW) wslot = 5'(SL_MLOW);
    else if (cmd_code == CMD_SLEW) wslot = 5'(SL_SLEW);
    else if (cmd_code == CMD_LOADLINE) wslot = 5'(SL_LOADLINE);
    else if (cmd_code == CMD_DUTY) wslot = 5'(SL_DUTY);
    else if (cmd_code == CMD_FSW) wslot = 5'(SL_FSW);
    else begin
      wslot = 5'h1f;
      hit = 1'b0;
    end
  end

  // Commands are taken only while idle; the host waits on cmd_busy
  assign is_cmd = cmd_valid && clk_en && state_reg == ST_IDLE;

  // ----------------------------------------------------------------
  // Enable pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
    end else if (clk_en) begin
      en_s1_reg <= enable_pin;
      en_s2_reg <= en_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Strap synchronisers
  // ----------------------------------------------------------------
  // Straps settle before reset ends and then stay put, so the words
  // cross as levels; the init walk reaches the first strap slot only
  // after both stages hold the strap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vout_s1_reg <= 16'h0000;
      vout_s2_reg <= 16'h0000;
      fsw_s1_reg <= 16'h0000;
      fsw_s2_reg <= 16'h0000;
    end else if (clk_en) begin
      vout_s1_reg <= strap_vout;
      vout_s2_reg <= vout_s1_reg;
      fsw_s1_reg <= strap_fsw;
      fsw_s2_reg <= fsw_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: init load, store and restore
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_INIT;
      slot_reg <= 4'h0;
      wait_reg <= 4'h0;
      to_user_reg <= 1'b0;
      cmd_refused <= 1'b0;
    end else if (clk_en) begin
      cmd_refused <= 1'b0;
      case (state_reg)
        // Init loads the user level; unstored slots fall back to defaults
        ST_INIT: begin
          to_user_reg <= 1'b1;
          slot_reg <= 4'h0;
          state_reg <= ST_LOAD;
        end
        ST_IDLE: begin
          if (cmd_valid && cmd_write) begin
            if (cmd_code == CMD_STORE_DEF || cmd_code == CMD_STORE_USER) begin
              to_user_reg <= (cmd_code == CMD_STORE_USER);
              slot_reg <= 4'h0;
              wait_reg <= NV_WAIT;
              state_reg <= ST_STORE;
            end else if (cmd_code == CMD_RESTORE_DEF) begin
              if (default_restore_ok) begin
                to_user_reg <= 1'b0;
                slot_reg <= 4'h0;
                state_reg <= ST_LOAD;
              end else cmd_refused <= 1'b1;
            end else if (cmd_code == CMD_RESTORE_USER) begin
              if (user_restore_ok) begin
                to_user_reg <= 1'b1;
                slot_reg <= 4'h0;
                state_reg <= ST_LOAD;
              end else cmd_refused <= 1'b1;
            end else if (!hit) cmd_refused <= 1'b1;
          end else if (cmd_valid && !hit && cmd_code != CMD_VFMT) begin
            cmd_refused <= 1'b1;
          end
        end
        // Every slot waits NV_WAIT cycles, the pace of a slow store write
        ST_STORE: begin
          if (wait_reg == 4'h0) begin
            wait_reg <= NV_WAIT;
            if (slot_reg == 4'(NSLOT - 1)) state_reg <= ST_WAIT;
            else slot_reg <= slot_reg + 4'h1;
          end else wait_reg <= wait_reg - 4'h1;
        end
        ST_LOAD: begin
          if (slot_reg == 4'(NSLOT - 1)) state_reg <= ST_WAIT;
          else slot_reg <= slot_reg + 4'h1;
        end
        ST_WAIT: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Stores, with per-slot written flags
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSLOT; g++) begin : g_slot
      logic st_hit;
      assign st_hit = state_reg == ST_STORE && slot_reg == 4'(g) &&
                      wait_reg == 4'h0 && dirty_reg[g];
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          def_mem[g] <= 16'h0000;
          user_mem[g] <= 16'h0000;
          def_valid_reg[g] <= 1'b0;
          user_valid_reg[g] <= 1'b0;
        end else if (clk_en && st_hit) begin
          if (to_user_reg) begin
            user_mem[g] <= work_reg[g];
            user_valid_reg[g] <= 1'b1;
          end else begin
            def_mem[g] <= work_reg[g];
            def_valid_reg[g] <= 1'b1;
          end
        end
      end
      // Working value; a host write in the same cycle cannot occur
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          work_reg[g] <= 16'h0000;
          dirty_reg[g] <= 1'b0;
        end else if (clk_en) begin
          if (state_reg == ST_LOAD && slot_reg == 4'(g)) begin
            dirty_reg[g] <= 1'b0;
            if (to_user_reg && user_valid_reg[g])
              work_reg[g] <= user_mem[g];
            else if (def_valid_reg[g])
              work_reg[g] <= def_mem[g];
            else if (to_user_reg || def_valid_reg == '0) begin
              case (g)
                SL_RUN: work_reg[g] <= {8'h00, RST_RUN_CTRL};
                SL_ONSRC: work_reg[g] <= {8'h00, RST_ON_SRC};
                SL_TARGET: work_reg[g] <= vout_s2_reg;
                SL_TRIM: work_reg[g] <= RST_TRIM;
                SL_CAL: work_reg[g] <= RST_CAL;
                SL_UPPER:
                  work_reg[g] <= vout_s2_reg + 16'(vout_s2_reg / 16'd10);
                SL_MHIGH:
                  work_reg[g] <= vout_s2_reg + 16'(vout_s2_reg / 16'd20);
                SL_MLOW:
                  work_reg[g] <= vout_s2_reg - 16'(vout_s2_reg / 16'd20);
                SL_SLEW: work_reg[g] <= RST_SLEW;
                SL_LOADLINE: work_reg[g] <= RST_LOADLINE;
                SL_DUTY: work_reg[g] <= RST_DUTY;
                SL_FSW: work_reg[g] <= fsw_s2_reg;
                default: work_reg[g] <= 16'h0000;
              endcase
            end
          end else if (is_cmd && cmd_write && wslot == 5'(g)) begin
            work_reg[g] <= (g <= SL_ONSRC) ? {8'h00, cmd_wdata[7:0]}
                                           : cmd_wdata;
            dirty_reg[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_data <= 16'h0000;
      rsp_valid <= 1'b0;
    end else if (clk_en) begin
      // Reads of unknown codes give no answer, only a refusal
      rsp_valid <= is_cmd && !cmd_write && (hit || cmd_code == CMD_VFMT);
      if (is_cmd && !cmd_write) begin
        if (cmd_code == CMD_VFMT) rsp_data <= {8'h00, RST_VFMT};
        else if (hit) rsp_data <= work_reg[wslot[3:0]];
        else rsp_data <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Active settings toward the power stage
  // ----------------------------------------------------------------
  always_comb begin
    // Trim applies to the nominal target only; the offset is added to margin targets too
    if (work_reg[SL_RUN][MARGIN_HI:MARGIN_LO] == MG_HIGH)
      tgt_next = work_reg[SL_MHIGH];
    else if (work_reg[SL_RUN][MARGIN_HI:MARGIN_LO] == MG_LOW)
      tgt_next = work_reg[SL_MLOW];
    else
      tgt_next = work_reg[SL_TARGET] + work_reg[SL_TRIM];
    tgt_next = tgt_next + work_reg[SL_CAL];
    if (tgt_next > work_reg[SL_UPPER]) tgt_next = work_reg[SL_UPPER];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_on <= 1'b0;
      active_target <= 16'h0000;
      slew_out <= 16'h0000;
      loadline_out <= 16'h0000;
      duty_limit_out <= 16'h0000;
      fsw_out <= 16'h0000;
      upper_limit_out <= 16'h0000;
      cmd_busy <= 1'b1;
    end else if (clk_en) begin
      cmd_busy <= state_reg != ST_IDLE;
      output_on <= (!work_reg[SL_ONSRC][ONSRC_CMD_BIT] ||
                    work_reg[SL_RUN][RUN_ON_BIT]) &&
                   (!work_reg[SL_ONSRC][ONSRC_PIN_BIT] || en_s2_reg);
      active_target <= tgt_next;
      slew_out <= work_reg[SL_SLEW];
      loadline_out <= work_reg[SL_LOADLINE];
      duty_limit_out <= work_reg[SL_DUTY];
      fsw_out <= work_reg[SL_FSW];
      upper_limit_out <= work_reg[SL_UPPER];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  vfmt_read_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && is_cmd && !cmd_write && cmd_code == CMD_VFMT |=>
    rsp_valid && rsp_data == 16'h0013)
    else $error("format read wrong");
  restore_deny_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && state_reg == ST_IDLE && cmd_valid && cmd_write &&
    cmd_code == CMD_RESTORE_USER && !user_restore_ok |=>
    cmd_refused && state_reg == ST_IDLE)
    else $error("denied restore ran");
  store_seq_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && state_reg == ST_IDLE && cmd_valid && cmd_write &&
    cmd_code == CMD_STORE_USER |=> state_reg == ST_STORE && to_user_reg)
    else $error("store not started");
  init_load_a: assert property (@(posedge clk) disable iff (!resetn)
    resetn && clk_en && state_reg == ST_INIT |=> state_reg == ST_LOAD)
    else $error("init load missing");
  def_deny_a: assert property (@(posedge clk) disable iff (!resetn)
    is_cmd && cmd_write && cmd_code == CMD_RESTORE_DEF &&
    !default_restore_ok |=> cmd_refused && state_reg == ST_IDLE)
    else $error("denied default restore ran");
  def_load_a: assert property (@(posedge clk) disable iff (!resetn)
    is_cmd && cmd_write && cmd_code == CMD_RESTORE_DEF &&
    default_restore_ok |=> state_reg == ST_LOAD && !to_user_reg)
    else $error("default restore not started");
  user_load_a: assert property (@(posedge clk) disable iff (!resetn)
    is_cmd && cmd_write && cmd_code == CMD_RESTORE_USER &&
    user_restore_ok |=> state_reg == ST_LOAD && to_user_reg)
    else $error("user restore not started");
  store_def_a: assert property (@(posedge clk) disable iff (!resetn)
    is_cmd && cmd_write && cmd_code == CMD_STORE_DEF |=>
    state_reg == ST_STORE && !to_user_reg)
    else $error("default store not started");
  store_busy_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && state_reg == ST_STORE |=> cmd_busy)
    else $error("busy low during store");
  trim_write_a: assert property (@(posedge clk) disable iff (!resetn)
    is_cmd && cmd_write && cmd_code == CMD_TRIM |=>
    work_reg[SL_TRIM] == $past(cmd_wdata))
    else $error("trim write lost");
  vfmt_ro_a: assert property (@(posedge clk) disable iff (!resetn)
    is_cmd && cmd_write && cmd_code == CMD_VFMT |=> cmd_refused)
    else $error("format write taken");

  // ----------------------------------------------------------------
  // Checks on the active settings
  // ----------------------------------------------------------------
  target_clamp_a: assert property (@(posedge clk) disable iff (!resetn)
    active_target <= upper_limit_out)
    else $error("target above upper limit");
  margin_high_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_en && work_reg[SL_RUN][MARGIN_HI:MARGIN_LO] == MG_HIGH &&
    work_reg[SL_MHIGH] + work_reg[SL_CAL] <= work_reg[SL_UPPER] |=>
    active_target == $past(work_reg[SL_MHIGH] + work_reg[SL_CAL]))
    else $error("margin high target wrong");
endmodule
`default_nettype wire

//--- pcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model (
  input wire logic clk, // System clock
  input wire logic cmd_busy, // Store or restore running
  input wire logic rsp_valid, // Read answer strobe
  input wire logic [15:0] rsp_data, // Read answer data
  input wire logic cmd_refused, // Refusal pulse
  output logic cmd_valid, // Command strobe
  output logic [7:0] cmd_code, // Command code
  output logic cmd_write, // Write or send byte
  output logic [15:0] cmd_wdata // Write data
);
  // One less than the idle cycles inserted before each command
  int idle_gap = 1;

  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_write = 1'b0;
    cmd_wdata = 16'h0000;
  end

  // ------------------------------------------------------------------
  // One command with its answer window
  // ------------------------------------------------------------------
  task automatic xfer(input logic [7:0] code, input logic wr,
                      input logic [15:0] wd, output logic [15:0] rd,
                      output logic got, output logic refused);
    int n;
    n = 0;
    got = 1'b0;
    refused = 1'b0;
    rd = 16'h0000;
    repeat (idle_gap + 1) @(posedge clk);
    while (cmd_busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_write <= wr;
    cmd_wdata <= wd;
    @(posedge clk);
    // Released lines show inverted data so stale values are never reused
    cmd_valid <= 1'b0;
    cmd_code <= ~code;
    cmd_write <= ~wr;
    cmd_wdata <= ~wd;
    repeat (2) begin
      @(posedge clk);
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        rd = rsp_data;
      end
      if (cmd_refused === 1'b1) begin
        refused = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import pcs_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic user_ok = 1'b0;
  logic def_ok = 1'b0;
  logic enable_pin = 1'b0;
  logic [15:0] strap_vout = 16'h1900;
  logic [15:0] strap_fsw = 16'h0190;
  logic cmd_valid, cmd_write, rsp_valid, cmd_busy, cmd_refused, output_on;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_data, active_target, slew_out, loadline_out;
  logic [15:0] duty_limit_out, fsw_out, upper_limit_out, rd;
  logic got, refd;
  int n_fail = 0;
  int check_count = 0;
  localparam logic [7:0] CODES [13] = '{CMD_RUN_CTRL, CMD_ON_SRC, CMD_VFMT,
    CMD_TARGET, CMD_TRIM, CMD_CAL, CMD_UPPER, CMD_MHIGH, CMD_MLOW, CMD_SLEW,
    CMD_LOADLINE, CMD_DUTY, CMD_FSW};

  always #5 clk = ~clk;

  pcs_config_store i_dut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
    .cmd_wdata(cmd_wdata), .strap_vout(strap_vout), .strap_fsw(strap_fsw),
    .user_restore_ok(user_ok), .default_restore_ok(def_ok),
    .enable_pin(enable_pin), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .cmd_busy(cmd_busy), .cmd_refused(cmd_refused), .output_on(output_on),
    .active_target(active_target), .slew_out(slew_out),
    .loadline_out(loadline_out), .duty_limit_out(duty_limit_out),
    .fsw_out(fsw_out), .upper_limit_out(upper_limit_out));

  pcs_host_model i_host (.clk(clk), .cmd_busy(cmd_busy),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_refused(cmd_refused),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
    .cmd_wdata(cmd_wdata));

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] d);
    i_host.xfer(code, 1'b1, d, rd, got, refd);
  endtask

  task automatic rdc(input logic [7:0] code, input logic [15:0] exp);
    i_host.xfer(code, 1'b0, 16'h0000, rd, got, refd);
    chk($sformatf("answer %h", code), {15'h0000, got}, 16'h0001);
    chk($sformatf("read %h", code), rd, exp);
  endtask

  task automatic send(input logic [7:0] code, input logic exp_ref);
    int n;
    i_host.xfer(code, 1'b1, 16'h0000, rd, got, refd);
    chk($sformatf("refusal %h", code), {15'h0000, refd}, {15'h0000, exp_ref});
    for (n = 0; n < 80 && cmd_busy !== 1'b0; n++) @(posedge clk);
    chk("busy done", {15'h0000, cmd_busy}, 16'h0000);
  endtask

  function automatic logic [15:0] pick(int s);
    case (s)
      0: return {15'h0000, output_on};
      1: return active_target;
      2: return slew_out;
      3: return loadline_out;
      4: return duty_limit_out;
      5: return fsw_out;
      default: return upper_limit_out;
    endcase
  endfunction

  // Level outputs settle within a few cycles of the command
  task automatic lvl(input int s, input logic [15:0] exp);
    int n;
    for (n = 0; n < 8 && pick(s) !== exp; n++) @(posedge clk);
    chk($sformatf("level %0d", s), pick(s), exp);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_values;
    logic [15:0] exp [13];
    logic [15:0] lv [7];
    exp = '{16'h0000, 16'h0016, 16'h0013, 16'h1900, 16'h0000, 16'h0000,
      16'h1b80, 16'h1a40, 16'h17c0, 16'hba00, 16'h0000, 16'head6, 16'h0190};
    lv = '{16'h0000, 16'h1900, 16'hba00, 16'h0000, 16'head6, 16'h0190,
      16'h1b80};
    for (int i = 0; i < 13; i++) rdc(CODES[i], exp[i]);
    for (int s = 0; s < 7; s++) lvl(s, lv[s]);
  endtask

  task automatic t_rw;
    logic [15:0] d;
    i_host.idle_gap = 0;
    for (int i = 0; i < 13; i++) wr(CODES[i], 16'h0300 + 16'(i));
    for (int i = 0; i < 13; i++) begin
      d = (i < 2) ? 16'(i) : (i == 2) ? 16'h0013 : 16'h0300 + 16'(i);
      rdc(CODES[i], d);
    end
    lvl(2, 16'h0309);
    lvl(3, 16'h030a);
    lvl(4, 16'h030b);
    lvl(5, 16'h030c);
    lvl(6, 16'h0306);
    i_host.idle_gap = 3;
  endtask

  task automatic t_target;
    wr(CMD_UPPER, 16'h3000);
    wr(CMD_TARGET, 16'h1000);
    wr(CMD_TRIM, 16'h0010);
    wr(CMD_CAL, 16'h0020);
    wr(CMD_MHIGH, 16'h1200);
    wr(CMD_MLOW, 16'h0e00);
    wr(CMD_ON_SRC, 16'h0008);
    wr(CMD_RUN_CTRL, 16'h0080);
    lvl(0, 16'h0001);
    lvl(1, 16'h1030);
    wr(CMD_RUN_CTRL, 16'h00a0);
    lvl(1, 16'h1220);
    wr(CMD_RUN_CTRL, 16'h0090);
    lvl(1, 16'h0e20);
    wr(CMD_RUN_CTRL, 16'h0000);
    lvl(0, 16'h0000);
    wr(CMD_TRIM, 16'h0000);
    wr(CMD_CAL, 16'h0000);
    wr(CMD_TARGET, 16'h3100);
    lvl(1, 16'h3000);
    wr(CMD_ON_SRC, 16'h0004);
    enable_pin <= 1'b1;
    lvl(0, 16'h0001);
    enable_pin <= 1'b0;
    lvl(0, 16'h0000);
  endtask

  task automatic t_stores;
    wr(CMD_TRIM, 16'h1234);
    send(CMD_STORE_USER, 1'b0);
    wr(CMD_TRIM, 16'h5555);
    user_ok <= 1'b1;
    send(CMD_RESTORE_USER, 1'b0);
    rdc(CMD_TRIM, 16'h1234);
    user_ok <= 1'b0;
    wr(CMD_TRIM, 16'h7777);
    send(CMD_RESTORE_USER, 1'b1);
    rdc(CMD_TRIM, 16'h7777);
    wr(CMD_SLEW, 16'h1111);
    send(CMD_STORE_DEF, 1'b0);
    wr(CMD_SLEW, 16'h2222);
    wr(CMD_TRIM, 16'h4444);
    send(CMD_RESTORE_DEF, 1'b1);
    def_ok <= 1'b1;
    send(CMD_RESTORE_DEF, 1'b0);
    rdc(CMD_SLEW, 16'h1111);
    rdc(CMD_TRIM, 16'h7777);
    lvl(2, 16'h1111);
    user_ok <= 1'b1;
    send(CMD_RESTORE_USER, 1'b0);
    rdc(CMD_TRIM, 16'h1234);
  endtask

  task automatic stop_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset_values();
    t_rw();
    t_target();
    t_stores();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
